// ===== inc/isa_pkg.sv
// Package for the input signal allocator: register map, field layout, codes and bus types
package isa_pkg;

  // ==========================================================================
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int MAP_W = 16;
  localparam int PIN_N = 7;
  localparam int FUNC_N = 16;
  localparam int CODE_W = 4;
  localparam int DIGITS = 4;

  // ==========================================================================
  // Register byte addresses
  localparam logic [ADDR_W-1:0] OFS_MAP_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_MAP_B = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_MAP_C = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MAP_D = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_MAP_E = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_FUNC_STATE = 8'h18;
  localparam int MAP_REGS = 5;

  // ==========================================================================
  // Field positions and reset values
  localparam int ENABLE_DIGIT = 0;
  localparam logic [CODE_W-1:0] ALLOC_ON = 4'h1;
  localparam logic [MAP_W-1:0] MAP_RESET = 16'h0000;

  // ==========================================================================
  // Function codes
  localparam logic [CODE_W-1:0] CODE_LAST_PIN = 4'h6;
  localparam logic [CODE_W-1:0] CODE_ALWAYS_ON = 4'h7;
  localparam logic [CODE_W-1:0] CODE_ALWAYS_OFF = 4'h8;
  localparam logic [CODE_W-1:0] CODE_INV_BASE = 4'h9;

  // Function indices; function f sits in map word (f+1)/4, digit (f+1)%4
  localparam int F_SERVO_POWER = 0;
  localparam int F_PROP_OP = 1;
  localparam int F_FWD_LIMIT = 2;
  localparam int F_REV_LIMIT = 3;

  // ==========================================================================
  // AXI-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // AXI-Lite channel bundles
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W/8-1:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } isa_axi_m2s_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } isa_axi_s2m_t;

endpackage : isa_pkg

// ===== design/isa_allocator.sv
// Input signal allocator: routes seven connector inputs to sixteen input functions
`timescale 1ns/1ps
`default_nettype none

module isa_allocator #(
  parameter logic [isa_pkg::FUNC_N*isa_pkg::CODE_W-1:0] DEFAULT_CODES = 64'h8888888888654321
)(
  input wire logic aclk, // System clock, 200 MHz
  input wire logic aresetn, // Synchronous reset, active low
  input wire isa_pkg::isa_axi_m2s_t s_axi_req, // AXI-Lite master to slave
  output isa_pkg::isa_axi_s2m_t s_axi_rsp, // AXI-Lite slave to master
  input wire logic [isa_pkg::PIN_N-1:0] io_pin_in, // Connector inputs, 1 = high level
  output logic [isa_pkg::FUNC_N-1:0] func_active // Input functions, 1 = asserted
);

  // ==========================================================================
  // Register storage
  logic [isa_pkg::MAP_W-1:0] map_reg [isa_pkg::MAP_REGS];
  logic [isa_pkg::MAP_REGS*isa_pkg::MAP_W-1:0] map_flat;
  logic alloc_enable;

  // ==========================================================================
  // Write channel state
  logic aw_held;
  logic w_held;
  logic [isa_pkg::ADDR_W-1:0] aw_addr;
  logic [isa_pkg::DATA_W-1:0] w_data;
  logic [isa_pkg::DATA_W/8-1:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic wr_fire;
  logic [2:0] wr_index;
  logic wr_hit;
  logic [3:0] wr_map_idx;

  // ==========================================================================
  // Read channel state
  logic rvalid;
  logic [isa_pkg::DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic [isa_pkg::DATA_W-1:0] next_rdata;
  logic next_rhit;

  // Address decode to a map register index; anything else is not a map word
  function automatic logic [3:0] map_index(input logic [isa_pkg::ADDR_W-1:0] a);
    logic [3:0] idx;
    idx = 4'hF;
    case (a)
      isa_pkg::OFS_MAP_A: idx = 4'h0;
      isa_pkg::OFS_MAP_B: idx = 4'h1;
      isa_pkg::OFS_MAP_C: idx = 4'h2;
      isa_pkg::OFS_MAP_D: idx = 4'h3;
      isa_pkg::OFS_MAP_E: idx = 4'h4;
      default: idx = 4'hF;
    endcase
    return idx;
  endfunction : map_index

  // ==========================================================================
  // Handshake outputs; address and data are each refused while held or while bvalid is up, reads while rvalid is up
  assign s_axi_rsp.awready = !aw_held && !bvalid;
  assign s_axi_rsp.wready = !w_held && !bvalid;
  assign s_axi_rsp.bvalid = bvalid;
  assign s_axi_rsp.bresp = bresp;
  assign s_axi_rsp.arready = !rvalid;
  assign s_axi_rsp.rvalid = rvalid;
  assign s_axi_rsp.rdata = rdata;
  assign s_axi_rsp.rresp = rresp;

  // Both halves of a write are in hand once each is held
  assign wr_fire = aw_held && w_held && !bvalid;
  // Decode once; a function result cannot be part-selected directly
  assign wr_map_idx = map_index(aw_addr);
  assign wr_index = wr_map_idx[2:0];
  assign wr_hit = (wr_map_idx != 4'hF);

  // Address and data may arrive in either order, so each is latched alone
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (s_axi_req.awvalid && s_axi_rsp.awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_req.awaddr;
    end
    else if (wr_fire)
      aw_held <= 1'b0;
  end

  // Write data capture
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (s_axi_req.wvalid && s_axi_rsp.wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_req.wdata;
      w_strb <= s_axi_req.wstrb;
    end
    else if (wr_fire)
      w_held <= 1'b0;
  end

  // Write response; unmapped or read-only words answer SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid <= 1'b0;
      bresp <= isa_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? isa_pkg::RESP_OKAY : isa_pkg::RESP_SLVERR;
    end
    else if (s_axi_req.bready)
      bvalid <= 1'b0;
  end

  // ==========================================================================
  // Map registers, byte lanes 0 and 1 only; upper lanes are dropped
  generate
    for (genvar r = 0; r < isa_pkg::MAP_REGS; r++)
    begin : g_map
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          map_reg[r] <= isa_pkg::MAP_RESET;
        else if (wr_fire && wr_hit && wr_index == 3'(r))
        begin
          if (w_strb[0])
            map_reg[r][7:0] <= w_data[7:0];
          if (w_strb[1])
            map_reg[r][15:8] <= w_data[15:8];
        end
      end
      assign map_flat[r*isa_pkg::MAP_W +: isa_pkg::MAP_W] = map_reg[r];
    end
  endgenerate

  // ==========================================================================
  // Read decode
  always_comb
  begin
    next_rdata = '0;
    next_rhit = 1'b1;
    case (s_axi_req.araddr)
      isa_pkg::OFS_MAP_A: next_rdata[isa_pkg::MAP_W-1:0] = map_reg[0];
      isa_pkg::OFS_MAP_B: next_rdata[isa_pkg::MAP_W-1:0] = map_reg[1];
      isa_pkg::OFS_MAP_C: next_rdata[isa_pkg::MAP_W-1:0] = map_reg[2];
      isa_pkg::OFS_MAP_D: next_rdata[isa_pkg::MAP_W-1:0] = map_reg[3];
      isa_pkg::OFS_MAP_E: next_rdata[isa_pkg::MAP_W-1:0] = map_reg[4];
      isa_pkg::OFS_PIN_STATE: next_rdata[isa_pkg::PIN_N-1:0] = io_pin_in;
      isa_pkg::OFS_FUNC_STATE: next_rdata[isa_pkg::FUNC_N-1:0] = func_active;
      default: next_rhit = 1'b0;
    endcase
  end

  // Read answer one cycle after the address is taken, held until rready
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= isa_pkg::RESP_OKAY;
    end
    else if (s_axi_req.arvalid && s_axi_rsp.arready)
    begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= next_rhit ? isa_pkg::RESP_OKAY : isa_pkg::RESP_SLVERR;
    end
    else if (s_axi_req.rready)
      rvalid <= 1'b0;
  end

  // ==========================================================================
  // Routing; the enable digit falls back to the built-in map so a blank
  // configuration still leaves the drive with known inputs
  assign alloc_enable = (map_reg[0][isa_pkg::ENABLE_DIGIT*isa_pkg::CODE_W +: isa_pkg::CODE_W]
                         == isa_pkg::ALLOC_ON);

  generate
    for (genvar f = 0; f < isa_pkg::FUNC_N; f++)
    begin : g_func
      // Field slot skips the enable digit at the bottom of the first word
      localparam int SLOT = f + 1;
      localparam bit ACT_HIGH = (f == isa_pkg::F_FWD_LIMIT) || (f == isa_pkg::F_REV_LIMIT);
      logic [isa_pkg::CODE_W-1:0] code;
      logic [isa_pkg::CODE_W-1:0] pin_sel;
      logic pin_level;
      logic next_state;

      assign code = alloc_enable ? map_flat[SLOT*isa_pkg::CODE_W +: isa_pkg::CODE_W]
                                 : DEFAULT_CODES[f*isa_pkg::CODE_W +: isa_pkg::CODE_W];
      assign pin_sel = (code >= isa_pkg::CODE_INV_BASE) ?
                       4'(code - isa_pkg::CODE_INV_BASE) : code;
      // Every function taps the shared pin vector, so fan-out is free
      assign pin_level = io_pin_in[pin_sel[2:0]];

      always_comb
      begin
        if (code <= isa_pkg::CODE_LAST_PIN)
          next_state = ACT_HIGH ? pin_level : !pin_level;
        else if (code == isa_pkg::CODE_ALWAYS_ON)
          next_state = 1'b1;
        else if (code == isa_pkg::CODE_ALWAYS_OFF)
          next_state = 1'b0;
        else
          next_state = ACT_HIGH ? !pin_level : pin_level;
      end

      // Registered so downstream sees one glitch-free level per cycle
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          func_active[f] <= 1'b0;
        else
          func_active[f] <= next_state;
      end
    end
  endgenerate

endmodule : isa_allocator

`default_nettype wire

// ===== tb/isa_checker.sv
// Port-level timing checks for the input signal allocator
`timescale 1ns/1ps
`default_nettype none
module isa_checker (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, active low
  input wire isa_pkg::isa_axi_m2s_t s_axi_req, // Bus request
  input wire isa_pkg::isa_axi_s2m_t s_axi_rsp, // Bus answer
  input wire logic [isa_pkg::PIN_N-1:0] io_pin_in, // Connector levels
  input wire logic [isa_pkg::FUNC_N-1:0] func_active // Function states
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========
  // Handshake steps
  sequence s_wr_both;
    s_axi_req.awvalid && s_axi_rsp.awready && s_axi_req.wvalid && s_axi_rsp.wready;
  endsequence
  sequence s_rd_take;
    s_axi_req.arvalid && s_axi_rsp.arready;
  endsequence
  // ==========
  // Reset is checked while asserted, so it cannot be disabled by itself
  a_reset_clear: assert property (disable iff (1'b0) !aresetn |=>
    !s_axi_rsp.bvalid && !s_axi_rsp.rvalid && func_active == '0) else $error("reset state wrong");
  a_write_answer: assert property (s_wr_both |-> ##2 s_axi_rsp.bvalid)
    else $error("write answer late");
  a_write_ro: assert property (s_wr_both and (s_axi_req.awaddr == isa_pkg::OFS_PIN_STATE)
    |-> ##2 s_axi_rsp.bresp == isa_pkg::RESP_SLVERR) else $error("read-only write accepted");
  a_read_answer: assert property (s_rd_take |=> s_axi_rsp.rvalid)
    else $error("read answer late");
  a_read_unmapped: assert property (s_rd_take and (s_axi_req.araddr > isa_pkg::OFS_FUNC_STATE)
    |=> s_axi_rsp.rresp == isa_pkg::RESP_SLVERR) else $error("unmapped read accepted");
  a_ar_blocked: assert property (s_axi_rsp.rvalid |-> !s_axi_rsp.arready)
    else $error("read taken while busy");
  a_aw_blocked: assert property (s_axi_rsp.bvalid |-> !s_axi_rsp.awready && !s_axi_rsp.wready)
    else $error("write taken while busy");
  // Functions may only move when a pin or the map moved the cycle before
  a_func_stable: assert property ($past(aresetn) && $stable(io_pin_in)
    && !$rose(s_axi_rsp.bvalid) |=> $stable(func_active)) else $error("function moved alone");
endmodule : isa_checker
bind isa_allocator isa_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_req(s_axi_req),
  .s_axi_rsp(s_axi_rsp), .io_pin_in(io_pin_in), .func_active(func_active));
`default_nettype wire

// ===== tb/isa_field_model.sv
// Field contacts that drive the connector inputs
`timescale 1ns/1ps
`default_nettype none
module isa_field_model (
  input wire logic aclk, // Clock
  input wire logic [isa_pkg::PIN_N-1:0] contacts, // Wanted contact levels
  output logic [isa_pkg::PIN_N-1:0] io_pin_in // Levels at the connector
);
  // ==========
  // Contacts settle one edge after being moved; one driver only, set within reset
  always @(posedge aclk)
    io_pin_in <= contacts;
endmodule : isa_field_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the input signal allocator
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========
  // Stimulus and design
  localparam logic [63:0] DEF = 64'h8888888888654321; // Routing while custom map is off
  logic aclk;
  logic aresetn;
  isa_pkg::isa_axi_m2s_t req;
  isa_pkg::isa_axi_s2m_t rsp;
  logic [6:0] want;
  logic [6:0] pins;
  logic [15:0] func;
  logic [79:0] map;
  logic [31:0] rd;
  logic [1:0] rs;
  int fail_count;
  int n_tests;
  isa_field_model u_field (.aclk(aclk), .contacts(want), .io_pin_in(pins));
  isa_allocator #(.DEFAULT_CODES(DEF)) DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req),
    .s_axi_rsp(rsp), .io_pin_in(pins), .func_active(func));
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // ==========
  // Expected routing; limits read high as active, the rest low
  function automatic logic [15:0] exp_func(input logic [79:0] m, input logic [6:0] p);
    logic [3:0] c;
    logic [3:0] ix;
    exp_func = '0;
    for (int f = 0; f < 16; f++)
    begin
      c = (m[3:0] == isa_pkg::ALLOC_ON) ? m[4 * f + 4 +: 4] : DEF[4 * f +: 4];
      ix = (c >= 4'h9) ? c - 4'h9 : c;
      if (c == 4'h7 || c == 4'h8)
        exp_func[f] = (c == 4'h7);
      else
        exp_func[f] = p[ix[2:0]] ^ (f != 2 && f != 3) ^ (c >= 4'h9);
    end
  endfunction : exp_func
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check
  // ==========
  // Bus cycles; valid held until its own ready, responses always accepted
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    while (!(aw && w))
    begin
      @(posedge aclk);
      aw |= rsp.awready;
      w |= rsp.wready;
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end
    while (!rsp.bvalid)
      @(posedge aclk);
    rs = rsp.bresp;
  endtask : wr
  task automatic rd_reg(input logic [7:0] a);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    do @(posedge aclk); while (!rsp.arready);
    req.arvalid <= 1'b0;
    while (!rsp.rvalid)
      @(posedge aclk);
    rd = rsp.rdata;
    rs = rsp.rresp;
  endtask : rd_reg
  task automatic put_map(input logic [79:0] m);
    map = m;
    for (int i = 0; i < 5; i++)
    begin
      wr(8'(4 * i), {16'h0000, m[16 * i +: 16]});
      check("write resp", 32'(isa_pkg::RESP_OKAY), 32'(rs));
      rd_reg(8'(4 * i));
      check("map readback", {16'h0000, m[16 * i +: 16]}, rd);
    end
  endtask : put_map
  task automatic drive(input logic [6:0] p);
    want <= p;
    repeat (3) @(posedge aclk);
    check("functions", 32'(exp_func(map, p)), 32'(func));
  endtask : drive
  // ==========
  // Scenarios
  task automatic t_reset;
    for (int i = 0; i < 5; i++)
    begin
      rd_reg(8'(4 * i));
      check("map reset", 32'h0, rd);
    end
    drive(7'h00);
    drive(7'h7F);
  endtask : t_reset
  task automatic t_codes;
    logic [79:0] m;
    for (int k = 0; k < 16; k += 8)
    begin
      m = 80'h1;
      // Every code once per pass; encoder request always lands on a pin; pass one
      // keeps safety inputs at default polarity, pass two inverts them and checks them
      for (int f = 0; f < 16; f++)
        m[4 * f + 4 +: 4] = 4'(f ^ k);
      put_map(m);
      drive(7'h55);
      drive(7'h2A);
      drive(7'h7F);
    end
  endtask : t_codes
  task automatic t_errors;
    wr(isa_pkg::OFS_PIN_STATE, 32'h0000_00FF);
    check("ro write", 32'(isa_pkg::RESP_SLVERR), 32'(rs));
    rd_reg(8'h1C);
    check("unmapped read", 32'(isa_pkg::RESP_SLVERR), 32'(rs));
    rd_reg(isa_pkg::OFS_PIN_STATE);
    check("pin state", 32'(want), rd);
    rd_reg(isa_pkg::OFS_FUNC_STATE);
    check("func state", 32'(exp_func(map, want)), rd);
  endtask : t_errors
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  // ==========
  // Main sequence and watchdog
  initial
  begin
    fail_count = 0;
    n_tests = 0;
    map = '0;
    want = '0;
    req = '0;
    req.bready = 1'b1;
    req.rready = 1'b1;
    req.wstrb = 4'hF;
    aresetn = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset;
    t_codes;
    t_errors;
    put_map({map[79:4], 4'h2});
    drive(7'h35);
    test_done;
  end
  initial
  begin
    repeat (5000) @(posedge aclk);
    fail_count++;
    test_done;
  end
endmodule : testbench
`default_nettype wire
